// ---- rtl/sis_defs.svh ----
// Constants for the serial, interrupt and standby register bank.
`ifndef SIS_DEFS_SVH
`define SIS_DEFS_SVH

// Register indices; the byte address is four times the index.
`define SIS_IDX_STANDBY   16'hFF8F
`define SIS_IDX_SERBUF    16'hFF9B
`define SIS_IDX_IEMASK    16'hFF9C
`define SIS_IDX_DMAEN     16'hFF9D
`define SIS_IDX_REQFLAG   16'hFF9E
`define SIS_IDX_EXT0MODE  16'hFF9F
`define SIS_IDX_IRQSTAT   16'hFFA0
`define SIS_IDX_IRQMASK   16'hFFA1
`define SIS_IDX_STATE     16'hFFA2

// Address decode: word index bits and the span above them.
`define SIS_IDX_LSB       2
`define SIS_IDX_MSB       17
`define SIS_SIZE_WORD     3'h2

// Standby register field positions.
`define SIS_STB_HALT_HI   3
`define SIS_STB_HALT_LO   2
`define SIS_STB_EXCH      1
`define SIS_STB_DRIVE     0

// Request flag clear code: key in bits 7..3, flag number in 2..0.
`define SIS_CLR_KEY_HI    7
`define SIS_CLR_KEY_LO    3
`define SIS_CLR_KEY       5'h0A
`define SIS_CLR_NUM_HI    2

// Sticky event bits of the interrupt status register.
`define SIS_EV_RX         0
`define SIS_EV_TX         1
`define SIS_EV_STOP       2
`define SIS_EV_EXT0       3
`define SIS_EV_W          4

// Reset values.
`define SIS_RST_BYTE      8'h00
`define SIS_RST_HALT      2'h0
`define SIS_RST_EV        4'h0

`endif

// ---- rtl/sis_pkg.sv ----
// Types shared by the serial, interrupt and standby register bank.
package sis_pkg;

  // Halt mode selected by the standby register field.
  typedef enum logic [1:0]
  {
    SIS_RUN   = 2'h0,
    SIS_STOP  = 2'h1,
    SIS_IDLE1 = 2'h2,
    SIS_IDLE2 = 2'h3
  } sis_halt_t;

endpackage : sis_pkg

// ---- rtl/sis_sync.sv ----
// Two flip-flop synchroniser for a level from outside the clock domain.
module sis_sync
(
  // Clock and reset.
  input  wire logic hclk,
  input  wire logic hresetn,
  // Asynchronous level in, synchronised level out.
  input  wire logic d,
  output logic      q
);

  // First stage, read only by the second stage.
  logic meta;
  // Next values of both stages.
  logic next_meta;
  logic next_q;

  // The chain simply shifts the input along.
  always_comb
  begin
    next_meta = d;
    next_q    = meta;
  end

  // Both stages clear on reset.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      meta <= 1'b0;
      q    <= 1'b0;
    end
    else
    begin
      meta <= next_meta;
      q    <= next_q;
    end
  end

endmodule : sis_sync

// ---- rtl/sis_sticky.sv ----
// Bank of sticky bits set by hardware and cleared by a clear vector.
module sis_sticky
#(
  parameter int W = 8
)
(
  // Clock and reset.
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // Set and clear vectors, one bit per flag.
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  // Flag state.
  output logic      [W-1:0] q
);

  // Next flag state.
  logic [W-1:0] next_q;

  // Refuse a width the bank cannot hold.
  if (W < 1)
  begin : g_chk
    $error("sis_sticky: width must be at least one");
  end

  // A set in the same cycle as a clear wins, so no event is lost.
  always_comb
  begin
    next_q = (q & ~clr) | set;
  end

  // Flags clear on reset.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      q <= '0;
    end
    else
    begin
      q <= next_q;
    end
  end

endmodule : sis_sticky

// ---- rtl/sis_regs.sv ----
// Serial buffer, interrupt control and standby registers on AHB-Lite.
`include "sis_defs.svh"

module sis_regs
(
  // Clock and reset.
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave port.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Serial channel data.
  input  wire logic [7:0]  rx_char,
  input  wire logic        rx_char_valid,
  output logic      [7:0]  tx_char,
  output logic             tx_char_load,
  // Interrupt sources, bits 6..0; bit 7 is the external pin.
  input  wire logic [6:0]  int_src_req,
  input  wire logic        ext_int0_pin,
  output logic             ext_int0_edge_sel,
  output logic      [7:0]  int_pending,
  output logic      [7:0]  dma_pending,
  // CPU standby events.
  input  wire logic        halt_exec,
  input  wire logic        register_exchange_instruction,
  input  wire logic        wake,
  output logic      [1:0]  halt_mode,
  output logic             internal_stop_signal,
  output logic             port_drive_in_stop,
  // Summary interrupt.
  output logic             irq
);

  // Address phase held for the data phase.
  logic        dp_write;
  logic [15:0] dp_idx;
  // Next values of the address phase registers.
  logic        next_dp_write;
  logic [15:0] next_dp_idx;
  logic [31:0] next_hrdata;

  // Software-visible storage.
  logic [7:0]  rx_buf;
  logic [7:0]  interrupt_enable_mask;
  logic [7:0]  micro_dma_enable;
  logic        ext0_edge;
  logic [1:0]  halt_sel;
  logic        exchange_toggle_flag;
  logic        drive_ctl;
  logic [`SIS_EV_W-1:0] ev_mask;
  // Next values of software-visible storage.
  logic [7:0]  next_rx_buf;
  logic [7:0]  next_tx_char;
  logic        next_tx_char_load;
  logic [7:0]  next_ie;
  logic [7:0]  next_dma;
  logic        next_ext0_edge;
  logic [1:0]  next_halt_sel;
  logic        next_exch;
  logic        next_drive;
  logic [`SIS_EV_W-1:0] next_ev_mask;

  // Stop signal and output mirrors.
  logic        next_stop;
  logic [7:0]  next_int_pending;
  logic [7:0]  next_dma_pending;
  logic        next_irq;

  // Flags, their set and clear vectors.
  logic [7:0]  request_flag;
  logic [7:0]  req_set;
  logic [7:0]  req_clr;
  logic [`SIS_EV_W-1:0] ev_stat;
  logic [`SIS_EV_W-1:0] ev_set;
  logic [`SIS_EV_W-1:0] ev_clr;

  // External pin after synchronising, and its previous level.
  logic        ext0_s;
  logic        ext0_prev;
  logic        ext0_trig;

  // Decoded accesses.
  logic        addr_sel;
  logic        wr_en;
  logic [7:0]  wbyte;
  logic        stop_enter;

  // Bring the external interrupt pin into the clock domain.
  sis_sync u_ext0_sync
  (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       (ext_int0_pin),
    .q       (ext0_s)
  );

  // Interrupt request flags.
  sis_sticky #(.W(8)) u_req_flags
  (
    .hclk    (hclk),
    .hresetn (hresetn),
    .set     (req_set),
    .clr     (req_clr),
    .q       (request_flag)
  );

  // Sticky event status for the summary interrupt.
  sis_sticky #(.W(`SIS_EV_W)) u_ev_stat
  (
    .hclk    (hclk),
    .hresetn (hresetn),
    .set     (ev_set),
    .clr     (ev_clr),
    .q       (ev_stat)
  );

  // Address phase decode: a whole-word single transfer, in the map span.
  always_comb
  begin
    addr_sel = hsel && htrans[1] && hready && (hsize == `SIS_SIZE_WORD)
               && (haddr[31:`SIS_IDX_MSB+1] == '0)
               && (haddr[`SIS_IDX_LSB-1:0] == '0);
    next_dp_write = addr_sel && hwrite;
    next_dp_idx   = haddr[`SIS_IDX_MSB:`SIS_IDX_LSB];
  end

  // Read data is chosen in the address phase and stands in the data phase.
  // Unmapped reads return zero; reserved bits read as zero.
  always_comb
  begin
    next_hrdata = '0;
    if (addr_sel && !hwrite)
    begin
      unique case (haddr[`SIS_IDX_MSB:`SIS_IDX_LSB])
        `SIS_IDX_STANDBY:
          next_hrdata[3:0] = {halt_sel, exchange_toggle_flag, drive_ctl};
        `SIS_IDX_SERBUF:   next_hrdata[7:0] = rx_buf;
        `SIS_IDX_IEMASK:   next_hrdata[7:0] = interrupt_enable_mask;
        `SIS_IDX_DMAEN:    next_hrdata[7:0] = micro_dma_enable;
        `SIS_IDX_REQFLAG:  next_hrdata[7:0] = request_flag;
        `SIS_IDX_EXT0MODE: next_hrdata[0]   = ext0_edge;
        `SIS_IDX_IRQSTAT:  next_hrdata[`SIS_EV_W-1:0] = ev_stat;
        `SIS_IDX_IRQMASK:  next_hrdata[`SIS_EV_W-1:0] = ev_mask;
        `SIS_IDX_STATE:    next_hrdata[0]   = internal_stop_signal;
        default:           next_hrdata = '0;
      endcase
    end
  end

  // Data phase write strobe and byte.
  always_comb
  begin
    wr_en = dp_write;
    wbyte = hwdata[7:0];
  end

  // External trigger: rising edge when the bit is set, high level if not.
  always_comb
  begin
    ext0_trig = ext0_edge ? (ext0_s && !ext0_prev) : ext0_s;
  end

  // Request flags: sources set them; only the clear code clears one.
  always_comb
  begin
    req_set = {ext0_trig, int_src_req};
    req_clr = '0;
    if (wr_en && dp_idx == `SIS_IDX_REQFLAG
        && wbyte[`SIS_CLR_KEY_HI:`SIS_CLR_KEY_LO] == `SIS_CLR_KEY)
    begin
      req_clr[wbyte[`SIS_CLR_NUM_HI:0]] = 1'b1;
    end
  end

  // Stop is entered by halt in stop mode unless pins must stay driven.
  always_comb
  begin
    stop_enter = halt_exec && (halt_sel == sis_pkg::SIS_STOP)
                 && !drive_ctl;
    if (drive_ctl)
    begin
      next_stop = 1'b0;
    end
    else if (stop_enter)
    begin
      next_stop = 1'b1;
    end
    else if (wake)
    begin
      next_stop = 1'b0;
    end
    else
    begin
      next_stop = internal_stop_signal;
    end
  end

  // Event status: set by block events, cleared by writing ones.
  always_comb
  begin
    ev_set = '0;
    ev_set[`SIS_EV_RX]   = rx_char_valid;
    ev_set[`SIS_EV_TX]   = wr_en && dp_idx == `SIS_IDX_SERBUF;
    ev_set[`SIS_EV_STOP] = stop_enter;
    ev_set[`SIS_EV_EXT0] = ext0_trig;
    ev_clr = '0;
    if (wr_en && dp_idx == `SIS_IDX_IRQSTAT)
    begin
      ev_clr = wbyte[`SIS_EV_W-1:0];
    end
  end

  // Register writes and hardware updates of the stored fields.
  always_comb
  begin
    next_rx_buf       = rx_char_valid ? rx_char : rx_buf;
    next_tx_char      = tx_char;
    next_tx_char_load = 1'b0;
    next_ie           = interrupt_enable_mask;
    next_dma          = micro_dma_enable;
    next_ext0_edge    = ext0_edge;
    next_halt_sel     = halt_sel;
    next_drive        = drive_ctl;
    next_ev_mask      = ev_mask;
    // The flag is read-only and flips per exchange instruction.
    next_exch = exchange_toggle_flag
                ^ register_exchange_instruction;
    if (wr_en)
    begin
      unique case (dp_idx)
        `SIS_IDX_STANDBY:
        begin
          next_halt_sel = wbyte[`SIS_STB_HALT_HI:`SIS_STB_HALT_LO];
          next_drive    = wbyte[`SIS_STB_DRIVE];
        end
        `SIS_IDX_SERBUF:
        begin
          // Transmit storage is separate from the receive buffer.
          next_tx_char      = wbyte;
          next_tx_char_load = 1'b1;
        end
        `SIS_IDX_IEMASK:   next_ie        = wbyte;
        `SIS_IDX_DMAEN:    next_dma       = wbyte;
        `SIS_IDX_EXT0MODE: next_ext0_edge = wbyte[0];
        `SIS_IDX_IRQMASK:  next_ev_mask   = wbyte[`SIS_EV_W-1:0];
        default:
        begin
          next_halt_sel = halt_sel;
        end
      endcase
    end
  end

  // Registered outputs gated by the enable registers.
  always_comb
  begin
    next_int_pending = request_flag & interrupt_enable_mask;
    next_dma_pending = request_flag & micro_dma_enable;
    next_irq         = |(ev_stat & ev_mask);
  end

  // All state of the bank but the flags and the synchroniser, cleared to its reset values.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_write              <= 1'b0;
      dp_idx                <= '0;
      hrdata                <= '0;
      hreadyout             <= 1'b1;
      hresp                 <= 1'b0;
      rx_buf                <= `SIS_RST_BYTE;
      tx_char               <= `SIS_RST_BYTE;
      tx_char_load          <= 1'b0;
      interrupt_enable_mask <= `SIS_RST_BYTE;
      micro_dma_enable      <= `SIS_RST_BYTE;
      ext0_edge             <= 1'b0;
      ext0_prev             <= 1'b0;
      halt_sel              <= `SIS_RST_HALT;
      exchange_toggle_flag  <= 1'b0;
      drive_ctl             <= 1'b0;
      ev_mask               <= `SIS_RST_EV;
      internal_stop_signal  <= 1'b0;
      int_pending           <= `SIS_RST_BYTE;
      dma_pending           <= `SIS_RST_BYTE;
      irq                   <= 1'b0;
      halt_mode             <= `SIS_RST_HALT;
      port_drive_in_stop    <= 1'b0;
      ext_int0_edge_sel     <= 1'b0;
    end
    else
    begin
      dp_write              <= next_dp_write;
      dp_idx                <= next_dp_idx;
      hrdata                <= next_hrdata;
      hreadyout             <= 1'b1;
      hresp                 <= 1'b0;
      rx_buf                <= next_rx_buf;
      tx_char               <= next_tx_char;
      tx_char_load          <= next_tx_char_load;
      interrupt_enable_mask <= next_ie;
      micro_dma_enable      <= next_dma;
      ext0_edge             <= next_ext0_edge;
      ext0_prev             <= ext0_s;
      halt_sel              <= next_halt_sel;
      exchange_toggle_flag  <= next_exch;
      drive_ctl             <= next_drive;
      ev_mask               <= next_ev_mask;
      internal_stop_signal  <= next_stop;
      int_pending           <= next_int_pending;
      dma_pending           <= next_dma_pending;
      irq                   <= next_irq;
      halt_mode             <= next_halt_sel;
      port_drive_in_stop    <= next_drive;
      ext_int0_edge_sel     <= next_ext0_edge;
    end
  end

endmodule : sis_regs

// ---- verif/sis_regs_chk.sv ----
// Checker for the serial, interrupt and standby register bank.
`include "sis_defs.svh"

module sis_regs_chk
(
  // Clock and reset.
  input wire logic        hclk,
  input wire logic        hresetn,
  // Bus request.
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  // Watched outputs and CPU events.
  input wire logic [7:0]  tx_char,
  input wire logic        tx_char_load,
  input wire logic        ext_int0_edge_sel,
  input wire logic        halt_exec,
  input wire logic        wake,
  input wire logic [1:0]  halt_mode,
  input wire logic        internal_stop_signal,
  input wire logic        port_drive_in_stop
);
  // Byte addresses of the written registers.
  localparam logic [31:0] AD_STB = {14'h0, `SIS_IDX_STANDBY, 2'h0};
  localparam logic [31:0] AD_BUF = {14'h0, `SIS_IDX_SERBUF, 2'h0};
  localparam logic [31:0] AD_EXT = {14'h0, `SIS_IDX_EXT0MODE, 2'h0};
  logic        wph;      // A word write is in its data phase.
  logic        next_wph; // Write accepted at this edge.
  logic [31:0] ap;       // Address of the write in data phase.
  logic        wr_stb;   // Data phase of a standby write.
  logic        wr_buf;   // Data phase of a serial buffer write.
  logic        wr_ext;   // Data phase of an edge-select write.

  // Decides whether this edge accepts a word write.
  always_comb
  begin
    next_wph = hsel && htrans[1] && hready && hwrite
      && hsize == `SIS_SIZE_WORD;
  end

  // Tracks the data phase of each accepted write.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wph <= 1'b0;
      ap  <= 32'h0;
    end
    else
    begin
      wph <= next_wph;
      ap  <= haddr;
    end
  end

  assign wr_stb = wph && ap == AD_STB;
  assign wr_buf = wph && ap == AD_BUF;
  assign wr_ext = wph && ap == AD_EXT;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_tx_load;
    wr_buf |=> tx_char_load && tx_char == $past(hwdata[7:0]);
  endproperty
  a_tx_load: assert property (p_tx_load)
    else $error("transmit character not loaded");
  property p_tx_only;
    tx_char_load |-> $past(wr_buf);
  endproperty
  a_tx_only: assert property (p_tx_only)
    else $error("transmit load without buffer write");
  property p_halt_wr;
    wr_stb |=> halt_mode == $past(hwdata[3:2]);
  endproperty
  a_halt_wr: assert property (p_halt_wr)
    else $error("halt mode field not written");
  property p_halt_hold;
    !wr_stb |=> $stable(halt_mode);
  endproperty
  a_halt_hold: assert property (p_halt_hold)
    else $error("halt mode changed without write");
  property p_drive_wr;
    wr_stb |=> port_drive_in_stop == $past(hwdata[0]);
  endproperty
  a_drive_wr: assert property (p_drive_wr)
    else $error("drive bit not written");
  property p_stop_set;
    halt_exec && halt_mode == sis_pkg::SIS_STOP && !port_drive_in_stop
      && !wake && !wr_stb |=> internal_stop_signal;
  endproperty
  a_stop_set: assert property (p_stop_set)
    else $error("stop signal missed halt in stop mode");
  property p_stop_cause;
    $rose(internal_stop_signal) |->
      $past(halt_exec) && $past(halt_mode) == sis_pkg::SIS_STOP;
  endproperty
  a_stop_cause: assert property (p_stop_cause)
    else $error("stop signal rose without halt");
  property p_drive_hold;
    port_drive_in_stop [*2] |-> !internal_stop_signal;
  endproperty
  a_drive_hold: assert property (p_drive_hold)
    else $error("stop signal high while drive bit set");
  property p_edge_wr;
    wr_ext |=> ext_int0_edge_sel == $past(hwdata[0]);
  endproperty
  a_edge_wr: assert property (p_edge_wr)
    else $error("edge select not written");

  // Main scenarios seen.
  c_buf: cover property (wr_buf);
  c_stop: cover property ($rose(internal_stop_signal));
  c_ext: cover property (wr_ext);
endmodule : sis_regs_chk

bind sis_regs sis_regs_chk u_chk (.hclk, .hresetn, .hsel, .haddr,
  .htrans, .hwrite, .hsize, .hwdata, .hready, .tx_char, .tx_char_load,
  .ext_int0_edge_sel, .halt_exec, .wake, .halt_mode,
  .internal_stop_signal, .port_drive_in_stop);

// ---- verif/tb_sis_regs.sv ----
// Self-checking testbench for the register bank.
`include "sis_defs.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin num_errors++; \
  $display("mismatch at %0t: got %h exp %h", $time, g, e); end end

module tb_sis_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0]  htrans = 2'h0, halt_mode;
  logic [2:0]  hsize = 3'h2;
  logic        hreadyout, hresp, tx_char_load, ext_int0_edge_sel, irq;
  logic [7:0]  rx_char = 8'h00, tx_char, int_pending, dma_pending;
  logic [6:0]  int_src_req = 7'h00;
  logic        rx_char_valid = 1'b0, ext_int0_pin = 1'b0, wake = 1'b0;
  logic        halt_exec = 1'b0, register_exchange_instruction = 1'b0;
  logic        internal_stop_signal, port_drive_in_stop;
  int          num_errors = 0, checks = 0;

  // Bus clock of 25 ns.
  always #12.5 hclk = ~hclk;

  sis_regs u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .rx_char, .rx_char_valid, .tx_char, .tx_char_load, .int_src_req,
    .ext_int0_pin, .ext_int0_edge_sel, .int_pending, .dma_pending,
    .halt_exec, .register_exchange_instruction, .wake, .halt_mode,
    .internal_stop_signal, .port_drive_in_stop, .irq);

  // Turns a register index into its byte address.
  function automatic logic [31:0] ad(input logic [15:0] i);
    ad = {14'h0, i, 2'h0};
  endfunction : ad

  // Waits at rising edges until the slave is ready.
  task automatic wait_rdy();
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      num_errors++;
      $display("mismatch at %0t: ready timeout", $time);
    end
  endtask : wait_rdy

  // One single word transfer; read data taken at the data phase end.
  task automatic xfer(input logic [15:0] i, input logic w,
                      input logic [7:0] d);
    @(posedge hclk);
    haddr  <= ad(i);
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wait_rdy();
    rd = hrdata;
  endtask : xfer

  // Reads a register and compares its value.
  task automatic rchk(input logic [15:0] i, input logic [31:0] e);
    xfer(i, 1'b0, 8'h00);
    `CHK(rd, e)
    `CHK(hresp, 1'b0)
  endtask : rchk

  // Lets a number of clock cycles pass.
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask : tick

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : final_report

  // Cuts a hung run short.
  initial
  begin
    tick(5000);
    num_errors++;
    final_report();
  end

  // Main sequence of scenarios.
  initial
  begin
    tick(12);
    hresetn <= 1'b1;
    rchk(`SIS_IDX_STANDBY, 32'h0);
    rchk(`SIS_IDX_IEMASK, 32'h0);
    rchk(`SIS_IDX_REQFLAG, 32'h0);
    rchk(`SIS_IDX_EXT0MODE, 32'h0);
    rchk(16'hFFB0, 32'h0);
    // Enable and DMA masks gate the request flags.
    xfer(`SIS_IDX_IEMASK, 1'b1, 8'hA5);
    xfer(`SIS_IDX_DMAEN, 1'b1, 8'h5A);
    rchk(`SIS_IDX_IEMASK, 32'hA5);
    rchk(`SIS_IDX_DMAEN, 32'h5A);
    int_src_req <= 7'h03;
    tick(1);
    int_src_req <= 7'h00;
    tick(3);
    `CHK(int_pending, 8'h01)
    `CHK(dma_pending, 8'h02)
    rchk(`SIS_IDX_REQFLAG, 32'h03);
    xfer(`SIS_IDX_REQFLAG, 1'b1, 8'h50);
    xfer(`SIS_IDX_REQFLAG, 1'b1, 8'hFF);
    rchk(`SIS_IDX_REQFLAG, 32'h02);
    xfer(`SIS_IDX_REQFLAG, 1'b1, 8'h51);
    rchk(`SIS_IDX_REQFLAG, 32'h00);
    // Level then rising edge trigger of the external input.
    ext_int0_pin <= 1'b1;
    tick(5);
    ext_int0_pin <= 1'b0;
    tick(4);
    rchk(`SIS_IDX_REQFLAG, 32'h80);
    xfer(`SIS_IDX_REQFLAG, 1'b1, 8'h57);
    xfer(`SIS_IDX_EXT0MODE, 1'b1, 8'h01);
    rchk(`SIS_IDX_EXT0MODE, 32'h01);
    `CHK(ext_int0_edge_sel, 1'b1)
    ext_int0_pin <= 1'b1;
    tick(5);
    rchk(`SIS_IDX_REQFLAG, 32'h80);
    xfer(`SIS_IDX_REQFLAG, 1'b1, 8'h57);
    tick(4);
    rchk(`SIS_IDX_REQFLAG, 32'h00);
    // Separate receive and transmit storage.
    rx_char <= 8'h3C;
    rx_char_valid <= 1'b1;
    tick(1);
    rx_char_valid <= 1'b0;
    xfer(`SIS_IDX_SERBUF, 1'b1, 8'hC3);
    tick(1);
    `CHK(tx_char, 8'hC3)
    `CHK(tx_char_load, 1'b1)
    rchk(`SIS_IDX_SERBUF, 32'h3C);
    // Every halt mode, then the read-only exchange flag.
    for (int m = 0; m < 4; m++)
    begin
      xfer(`SIS_IDX_STANDBY, 1'b1, 8'(m << 2));
      tick(1);
      `CHK(halt_mode, 2'(m))
      rchk(`SIS_IDX_STANDBY, 32'(m << 2));
    end
    xfer(`SIS_IDX_STANDBY, 1'b1, 8'h02);
    rchk(`SIS_IDX_STANDBY, 32'h00);
    for (int k = 1; k < 3; k++)
    begin
      register_exchange_instruction <= 1'b1;
      tick(1);
      register_exchange_instruction <= 1'b0;
      rchk(`SIS_IDX_STANDBY, (k == 1) ? 32'h2 : 32'h0);
    end
    // Stop entry, wake, idle halt and drive bit.
    for (int s = 0; s < 3; s++)
    begin
      xfer(`SIS_IDX_STANDBY, 1'b1, s == 0 ? 8'h04 : s == 1 ? 8'h08 : 8'h05);
      halt_exec <= 1'b1;
      tick(1);
      halt_exec <= 1'b0;
      tick(1);
      `CHK(internal_stop_signal, s == 0)
      `CHK(port_drive_in_stop, s == 2)
      // The stop signal stays readable until wake clears it.
      if (s == 0)
        rchk(`SIS_IDX_STATE, 32'h1);
      wake <= 1'b1;
      tick(1);
      wake <= 1'b0;
    end
    // Summary interrupt: raise, mask and clear.
    xfer(`SIS_IDX_IRQSTAT, 1'b1, 8'h0F);
    xfer(`SIS_IDX_IRQMASK, 1'b1, 8'h01);
    rx_char_valid <= 1'b1;
    tick(1);
    rx_char_valid <= 1'b0;
    tick(2);
    `CHK(irq, 1'b1)
    xfer(`SIS_IDX_IRQMASK, 1'b1, 8'h00);
    tick(2);
    `CHK(irq, 1'b0)
    xfer(`SIS_IDX_IRQMASK, 1'b1, 8'h01);
    xfer(`SIS_IDX_IRQSTAT, 1'b1, 8'h01);
    tick(2);
    `CHK(irq, 1'b0)
    rchk(`SIS_IDX_IRQSTAT, 32'h00);
    final_report();
  end
endmodule : tb_sis_regs
